/* File: inc/dsl_regs.vh */
`ifndef DSL_REGS_VH
`define DSL_REGS_VH

// Serial word geometry, most significant bit first
`define DSL_WORD_BITS      24
`define DSL_CNT_BITS       5
`define DSL_CODE_BITS      16
`define DSL_CODE_MSB       15
`define DSL_CTRL_HI        23
`define DSL_CTRL_LO        16
`define DSL_LAST_BIT       5'h17
`define DSL_CNT_ZERO       5'h00
`define DSL_CNT_ONE        5'h01

// Control field: bits 17:16 select power-down, zero means normal running
`define DSL_PD_HI          17
`define DSL_PD_LO          16
`define DSL_PD_NORMAL      2'h0

// Reset values
`define DSL_CODE_RST       16'h0000
`define DSL_WORD_RST       24'h000000
`define DSL_PD_RST         2'h0
`define DSL_SEL_IDLE       1'b1
`define DSL_SCLK_RST       1'b0

// Top bit kept when one new bit enters the shift register
`define DSL_SHIFT_MSB      22

// Serial clock limit and the sampling clock frequency, both in MHz
`define DSL_SCLK_MAX_MHZ   30
`define DSL_MCLK_MHZ       200

`endif

/* File: design/dsl_sync2.v */
module dsl_sync2 #(
    // Level both stages hold in reset: the pin's idle level
    parameter [0:0] RST_VAL = 1'b0
) (
    // Clock and reset
    input  wire mclk_in,
    input  wire sys_rst_in,
    // Asynchronous level in, synchronised level out
    input  wire async_in,
    output wire sync_out
);

    reg meta_q;
    reg sync_q;

    // First stage feeds the second stage only
    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule // dsl_sync2

/* File: design/dsl_frontend.v */
// Function
// R1: Shifting enabled only while frame select low
// R2: Capture 24 bits on falling serial clock
// R3: After 24th edge, load code and update
// R4: Early frame select rise discards partial word
// R5: Reset loads zero code until valid write
// R6: Power-down chosen by command in word
// R7: Serial clock up to 30MHz accepted
// R8: MSB first; top control, low 16 code
`include "dsl_regs.vh"

module dsl_frontend (
    // Clock and reset
    input  wire        mclk_in,
    input  wire        sys_rst_in,
    // Serial link pins
    input  wire        frame_sel_n_in,
    input  wire        sclk_in,
    input  wire        sdata_in,
    // Converter register
    output reg  [15:0] dac_code_out,
    output reg  [1:0]  pwr_down_out,
    output reg         update_out,
    // Frame status
    output reg         frame_abort_out,
    output reg         busy_out
);

    localparam ST_IDLE  = 1'b0;
    localparam ST_SHIFT = 1'b1;

    wire       sel_n_s;
    wire       sclk_s;
    wire       sdata_s;
    reg        sclk_prev_q;
    reg        sel_n_prev_q;
    reg        state_q;
    reg        state_d;
    reg [4:0]  cnt_q;
    reg [4:0]  cnt_d;
    reg [23:0] word_q;
    reg [23:0] word_d;
    reg        load_d;
    reg        abort_d;
    wire       sclk_fall;
    wire       sel_rise;
    wire [23:0] word_full;

    // Decodes shared by the shift path and the frame status logic
    function dsl_fall;
        input prev_lvl;
        input cur_lvl;
        begin
            dsl_fall = prev_lvl & ~cur_lvl;
        end
    endfunction

    function dsl_rise;
        input prev_lvl;
        input cur_lvl;
        begin
            dsl_rise = ~prev_lvl & cur_lvl;
        end
    endfunction

    function [23:0] dsl_shift_in;
        input [23:0] word;
        input        bit_in;
        begin
            dsl_shift_in = {word[`DSL_SHIFT_MSB:0], bit_in};
        end
    endfunction

    function dsl_is_last;
        input [4:0] cnt;
        begin
            dsl_is_last = (cnt == `DSL_LAST_BIT);
        end
    endfunction

    function [4:0] dsl_cnt_next;
        input [4:0] cnt;
        begin
            dsl_cnt_next = cnt + `DSL_CNT_ONE;
        end
    endfunction

    function [15:0] dsl_code_field;
        input [23:0] word;
        begin
            dsl_code_field = word[`DSL_CODE_MSB:0];
        end
    endfunction

    function [1:0] dsl_pd_field;
        input [23:0] word;
        begin
            dsl_pd_field = word[`DSL_PD_HI:`DSL_PD_LO];
        end
    endfunction

    // Two flip-flops on each pin; at 200 MHz a 30 MHz serial clock still
    // gives at least three samples per half period, so no edge is missed
    // Select resets to its idle level, so no phantom frame follows reset
    dsl_sync2 #(
        .RST_VAL    (`DSL_SEL_IDLE)
    ) u_sync_sel (
        .mclk_in    (mclk_in),
        .sys_rst_in (sys_rst_in),
        .async_in   (frame_sel_n_in),
        .sync_out   (sel_n_s)
    );

    dsl_sync2 u_sync_sclk (
        .mclk_in    (mclk_in),
        .sys_rst_in (sys_rst_in),
        .async_in   (sclk_in),
        .sync_out   (sclk_s)
    );

    // Data passes the same two stages as the clock, so it stays aligned
    dsl_sync2 u_sync_data (
        .mclk_in    (mclk_in),
        .sys_rst_in (sys_rst_in),
        .async_in   (sdata_in),
        .sync_out   (sdata_s)
    );

    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sclk_prev_q  <= `DSL_SCLK_RST;
            sel_n_prev_q <= `DSL_SEL_IDLE;
        end else begin
            sclk_prev_q  <= sclk_s;
            sel_n_prev_q <= sel_n_s;
        end
    end

    assign sclk_fall = dsl_fall(sclk_prev_q, sclk_s); // R2 R7
    assign sel_rise  = dsl_rise(sel_n_prev_q, sel_n_s);
    assign word_full = dsl_shift_in(word_q, sdata_s); // R8

    // Frame sequencing; the select level, not its edge, ends a frame
    always @* begin
        state_d = state_q;
        cnt_d   = cnt_q;
        word_d  = word_q;
        load_d  = 1'b0;
        abort_d = 1'b0;
        case (state_q)
            ST_IDLE: begin
                cnt_d = `DSL_CNT_ZERO;
                if (!sel_n_s) begin
                    state_d = ST_SHIFT; // R1
                end
            end
            ST_SHIFT: begin
                if (sel_n_s) begin
                    // Partial word is dropped, converter untouched
                    state_d = ST_IDLE; // R4
                    cnt_d   = `DSL_CNT_ZERO;
                    abort_d = sel_rise & (cnt_q != `DSL_CNT_ZERO); // R4
                end else if (sclk_fall) begin
                    word_d = word_full; // R2
                    if (dsl_is_last(cnt_q)) begin
                        load_d = 1'b1; // R3
                        // Wraps, so further edges start a fresh word
                        cnt_d  = `DSL_CNT_ZERO;
                    end else begin
                        cnt_d = dsl_cnt_next(cnt_q);
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
                cnt_d   = `DSL_CNT_ZERO;
            end
        endcase
    end

    // Shift state: sequencer, bit counter and word
    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q <= ST_IDLE;
            cnt_q   <= `DSL_CNT_ZERO;
            word_q  <= `DSL_WORD_RST;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            word_q  <= word_d;
        end
    end

    // Converter register: zero from reset until the first complete word
    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            dac_code_out <= `DSL_CODE_RST; // R5
            pwr_down_out <= `DSL_PD_RST;
        end else if (load_d) begin
            // Only a complete word ever reaches the converter register
            dac_code_out <= dsl_code_field(word_full); // R3 R5 R8
            pwr_down_out <= dsl_pd_field(word_full); // R6
        end
    end

    // Frame pulses, one cycle each
    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            update_out      <= 1'b0;
            frame_abort_out <= 1'b0;
        end else begin
            update_out      <= load_d;
            frame_abort_out <= abort_d;
        end
    end

    // Busy follows the next state so it rises with the frame, not after it
    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            busy_out <= 1'b0;
        end else begin
            busy_out <= (state_d == ST_SHIFT); // R1
        end
    end

endmodule // dsl_frontend

/* File: verification/dsl_host_model.sv */
module dsl_host_model (
    // Serial link pins
    output logic frame_sel_n_out,
    output logic sclk_out,
    output logic sdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        frame_sel_n_out = 1'b1;
        sclk_out = 1'b1;
        sdata_out = 1'b0;
    end
    // Sends the top n bits of w; n below 24 abandons the frame on purpose
    task automatic send(input logic [23:0] w, input int n);
        frame_sel_n_out = 1'b0;
        for (int i = 23; i > 23 - n; i--) begin
            sclk_out = 1'b1;
            sdata_out = w[i];
            #80;
            sclk_out = 1'b0;
            #80;
        end
        sclk_out = 1'b1;
        #80;
        frame_sel_n_out = 1'b1;
        // Released line must not keep showing the last bit
        sdata_out = ~sdata_out;
        #80;
    endtask
endmodule // dsl_host_model

/* File: verification/dsl_frontend_chk.sv */
module dsl_frontend_chk (
    // Clock and reset
    input wire logic        mclk_in,
    input wire logic        sys_rst_in,
    // Serial link pins
    input wire logic        frame_sel_n_in,
    input wire logic        sclk_in,
    input wire logic        sdata_in,
    // Block outputs
    input wire logic [15:0] dac_code_out,
    input wire logic [1:0]  pwr_down_out,
    input wire logic        update_out,
    input wire logic        frame_abort_out,
    input wire logic        busy_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    a_upd_pulse: assert property (update_out |=> !update_out)
        else $error("update pulse longer than one cycle");
    a_abort_pulse: assert property (frame_abort_out |=> !frame_abort_out)
        else $error("abort pulse longer than one cycle");
    a_code_hold: assert property (!update_out |-> $stable(dac_code_out))
        else $error("code changed without an update");
    a_pd_hold: assert property (!update_out |-> $stable(pwr_down_out))
        else $error("power-down changed without an update");
    a_no_both: assert property (!(update_out && frame_abort_out))
        else $error("update and abort together");
    a_busy_idle: assert property (frame_sel_n_in[*6] |-> !busy_out)
        else $error("busy while deselected");
    a_upd_frame: assert property (update_out |-> !$past(frame_sel_n_in, 4))
        else $error("update outside a selected frame");
    a_abort_sel: assert property (frame_abort_out |-> $past(frame_sel_n_in, 3))
        else $error("abort without select release");
    a_upd_busy: assert property (update_out |-> busy_out)
        else $error("update while not busy");
    c_update: cover property (update_out);
    c_abort: cover property (frame_abort_out);
    c_pdown: cover property (update_out && pwr_down_out != 2'h0);
endmodule // dsl_frontend_chk
bind dsl_frontend dsl_frontend_chk dsl_frontend_chk_inst (.mclk_in,
    .sys_rst_in, .frame_sel_n_in, .sclk_in, .sdata_in, .dac_code_out,
    .pwr_down_out, .update_out, .frame_abort_out, .busy_out);

/* File: verification/dsl_frontend_tb.sv */
module dsl_frontend_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    wire         fs_n, sclk, sd, upd, abt, busy;
    wire  [15:0] code;
    wire  [1:0]  pd;
    int          bad_count = 0, num_checks = 0, n_upd = 0, n_abt = 0;
    always #2.5 mclk_in = ~mclk_in;
    always @(posedge mclk_in) begin
        n_upd <= n_upd + int'(upd);
        n_abt <= n_abt + int'(abt);
    end
    dsl_host_model dsl_host_model_inst (.frame_sel_n_out(fs_n),
        .sclk_out(sclk), .sdata_out(sd));
    dsl_frontend dsl_frontend_inst (.mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in), .frame_sel_n_in(fs_n), .sclk_in(sclk),
        .sdata_in(sd), .dac_code_out(code), .pwr_down_out(pd),
        .update_out(upd), .frame_abort_out(abt), .busy_out(busy));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic t_idle(input logic [15:0] c);
        chk(code, c);
        chk(busy, 0);
    endtask
    task automatic t_write(input logic [23:0] w);
        int u, a;
        u = n_upd;
        a = n_abt;
        dsl_host_model_inst.send(w, 24);
        chk(n_upd - u, 1);
        chk(n_abt - a, 0);
        chk(code, w[15:0]);
        chk(pd, w[17:16]);
    endtask
    task automatic t_abort(input int n);
        int u, a;
        logic [15:0] c;
        logic [1:0]  p;
        u = n_upd;
        a = n_abt;
        c = code;
        p = pd;
        dsl_host_model_inst.send(24'hffffff, n);
        chk(n_upd - u, 0);
        chk(n_abt - a, 1);
        chk(code, c);
        chk(pd, p);
    endtask
    // Reset in mid-run must drop the converter register back to zero
    task automatic t_reset;
        @(posedge mclk_in);
        #1 sys_rst_in = 1'b1;
        repeat (6) @(posedge mclk_in);
        #1 sys_rst_in = 1'b0;
        repeat (4) @(posedge mclk_in);
        #1;
        chk(code, 16'h0000);
        chk(pd, 2'h0);
        chk(busy, 1'b0);
    endtask
    initial begin
        repeat (6) @(posedge mclk_in);
        #1 sys_rst_in = 1'b0;
        repeat (4) @(posedge mclk_in);
        #1;
        t_idle(16'h0000);
        t_abort(23);
        t_idle(16'h0000);
        t_write(24'h00a5c3);
        for (int m = 1; m < 5; m++) t_write({6'h0, 2'(m), 16'h5a00 ^ 16'(m)});
        t_abort(1);
        t_write(24'hff0001);
        t_idle(16'h0001);
        t_reset;
        t_write(24'h02ffff);
        end_of_test;
    end
    // Whole sequence needs about 32 us
    initial begin
        #100us;
        bad_count++;
        end_of_test;
    end
endmodule // dsl_frontend_tb
